// file: mft_timer.sv
// Multi-function timer top: chain, watchdog, time base, RTC, interrupt registers.
// Assumes the CPU accesses data memory with one-cycle rd/wr strobes and an 8-bit address.
`timescale 1ns/100ps
`default_nettype none
// Function
// - secondary bit0 enables counter interrupt
// - secondary bit4 is counter request flag
// - other secondary bits read zero
// - flags stay set until serviced or cleared
// - oscillator chain runs during halt
// - RTC runs from crystal during halt
// - disabled watchdog ignores its instructions
// - watchdog counts in halt, wakes device
// - normal overflow: chip reset, set timeout
// - halt overflow: warm reset, set timeout
// - reset pin, clear, halt clear watchdog
// - mask selects single or paired clear
// - watchdog period 3*2^14 to 2^16
// - clears touch only last two stages
// - 7-stage divider plus 8-bit prescaler
// - LCD clock /8, buzzer /4../512
// - time base period 2^12..2^15 sets flag
// - time base vectors 08H when allowed
// - time base wakes unless flag preset
// - RTC factor 2^(8+code)
// - RTC flag bit6, vector 0CH
// - RTC pulse feeds counter A
// - primary bit0 is global enable
// - priority external, tb, rtc, counter
module mft_timer #(
	parameter logic [1:0] TB_SEL = 2'h3,
	parameter logic [2:0] BUZ_SEL = 3'h0,
	parameter logic WDT_ENABLE = 1'b1,
	parameter logic CLEAR_TWICE = 1'b0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Crystal tick, one cycle per 32768 Hz period
	input wire logic tick_en,
	// Data memory access
	input wire logic [7:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	// Core status
	input wire logic halted,
	input wire logic halt_entry,
	input wire logic stack_full,
	input wire logic irq_ack,
	input wire logic ext_irq_event,
	input wire logic counter_overflow,
	input wire logic external_reset_pin_n,
	// Watchdog instructions
	input wire logic watchdog_clear_single,
	input wire logic watchdog_clear_first,
	input wire logic watchdog_clear_second,
	// Interrupt request to core
	output logic irq_req,
	output logic [4:0] irq_vector,
	output logic wake_up,
	// Reset requests
	output logic chip_reset,
	output logic warm_reset,
	output logic timeout_status,
	// Clocks out
	output logic rtc_pulse,
	output logic lcd_clk,
	output logic buzzer_clk
);
	////////////////////////////////////////////////////////////////////////////////
	// Shared chain
	localparam int CW = mft_pkg::CHAIN_BITS;
	logic [CW-1:0] chain_count;
	logic [CW-1:0] tap_pulse;
	mft_chain #(.WIDTH(CW)) mft_chain_inst (
		.mclk(mclk),
		.reset(reset),
		.tick_en(tick_en),
		.count(chain_count),
		.tap_pulse(tap_pulse)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] primary_ff;
	logic [7:0] secondary_ff;
	logic [2:0] rtc_rate_ff;
	logic [7:0] rd_data_ff;
	logic wr_primary;
	logic wr_secondary;
	logic wr_rate;
	assign wr_primary = wr_en && (addr == mft_pkg::IRQ_CONTROL_PRIMARY_OFS);
	assign wr_secondary = wr_en && (addr == mft_pkg::IRQ_CONTROL_SECONDARY_OFS);
	assign wr_rate = wr_en && (addr == mft_pkg::RTC_RATE_SELECT_OFS);

	////////////////////////////////////////////////////////////////////////////////
	// Time-out taps
	// Tap k pulses once every 2^(k+1) ticks
	function automatic logic tap_at(input logic [CW-1:0] p, input int exp);
		tap_at = p[exp-1];
	endfunction : tap_at
	logic tb_timeout;
	logic rtc_timeout;
	logic wdt_stage;
	assign tb_timeout = tap_at(tap_pulse, 12 + int'(TB_SEL));
	assign rtc_timeout = tap_at(tap_pulse, mft_pkg::RTC_BASE_EXP + int'(rtc_rate_ff));
	// Watchdog counts the 2^14 carry into its last two stages
	assign wdt_stage = tap_at(tap_pulse, CW - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog
	logic wdt_overflow;
	logic wdt_hard_clear;
	assign wdt_hard_clear = ~external_reset_pin_n | halt_entry;
	mft_wdt mft_wdt_inst (
		.mclk(mclk),
		.reset(reset),
		.wdt_enable(WDT_ENABLE),
		.clear_twice(CLEAR_TWICE),
		.stage_pulse(wdt_stage),
		.hard_clear(wdt_hard_clear),
		.clr_single(watchdog_clear_single),
		.clr_first(watchdog_clear_first),
		.clr_second(watchdog_clear_second),
		.overflow(wdt_overflow)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt selection
	logic ext_pend;
	logic tb_pend;
	logic rtc_pend;
	logic cnt_pend;
	logic sel_ext;
	logic sel_tb;
	logic sel_rtc;
	logic sel_cnt;
	logic any_pend;
	logic [4:0] nxt_vector;
	assign ext_pend = primary_ff[mft_pkg::EXT_EN_BIT] & primary_ff[mft_pkg::EXT_FLAG_BIT];
	assign tb_pend = primary_ff[mft_pkg::TB_EN_BIT] & primary_ff[mft_pkg::TB_FLAG_BIT];
	assign rtc_pend = primary_ff[mft_pkg::RTC_EN_BIT] & primary_ff[mft_pkg::RTC_FLAG_BIT];
	assign cnt_pend = secondary_ff[mft_pkg::CNT_EN_BIT] & secondary_ff[mft_pkg::CNT_FLAG_BIT];
	// Nothing serviced with global enable low or stack full
	assign any_pend = primary_ff[mft_pkg::GLOBAL_EN_BIT] & ~stack_full
		& (ext_pend | tb_pend | rtc_pend | cnt_pend);
	// Fixed priority
	assign sel_ext = ext_pend;
	assign sel_tb = tb_pend & ~ext_pend;
	assign sel_rtc = rtc_pend & ~ext_pend & ~tb_pend;
	assign sel_cnt = cnt_pend & ~ext_pend & ~tb_pend & ~rtc_pend;
	assign nxt_vector = sel_ext ? mft_pkg::VEC_EXT : sel_tb ? mft_pkg::VEC_TB
		: sel_rtc ? mft_pkg::VEC_RTC : mft_pkg::VEC_CNT;
	logic ack;
	assign ack = irq_ack & irq_req;

	////////////////////////////////////////////////////////////////////////////////
	// Register next values: hardware set wins over clear
	logic [7:0] nxt_primary;
	logic [7:0] nxt_secondary;
	logic [7:0] prim_base;
	logic [7:0] sec_base;
	assign prim_base = wr_primary ? {1'b0, wr_data[6:0]} : primary_ff;
	assign sec_base = wr_secondary ? (wr_data & 8'h11) : secondary_ff;
	always_comb begin
		nxt_primary = prim_base;
		if (ack) begin
			nxt_primary[mft_pkg::GLOBAL_EN_BIT] = 1'b0;
			if (sel_ext) nxt_primary[mft_pkg::EXT_FLAG_BIT] = 1'b0;
			if (sel_tb) nxt_primary[mft_pkg::TB_FLAG_BIT] = 1'b0;
			if (sel_rtc) nxt_primary[mft_pkg::RTC_FLAG_BIT] = 1'b0;
		end
		if (ext_irq_event) nxt_primary[mft_pkg::EXT_FLAG_BIT] = 1'b1;
		if (tb_timeout) nxt_primary[mft_pkg::TB_FLAG_BIT] = 1'b1;
		if (rtc_timeout) nxt_primary[mft_pkg::RTC_FLAG_BIT] = 1'b1;
		nxt_secondary = sec_base;
		if (ack && sel_cnt) nxt_secondary[mft_pkg::CNT_FLAG_BIT] = 1'b0;
		if (counter_overflow) nxt_secondary[mft_pkg::CNT_FLAG_BIT] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Halt wake-up: flags already set at halt entry lose their wake ability
	logic [3:0] armed_ff;
	logic [3:0] flags_now;
	logic [3:0] flags_rise;
	assign flags_now = {secondary_ff[mft_pkg::CNT_FLAG_BIT], primary_ff[mft_pkg::RTC_FLAG_BIT],
		primary_ff[mft_pkg::TB_FLAG_BIT], primary_ff[mft_pkg::EXT_FLAG_BIT]};
	assign flags_rise = flags_now & armed_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Flip-flops
	logic warm_ff;
	logic chip_ff;
	logic wake_ff;
	logic to_ff;
	logic irq_ff;
	logic [4:0] vec_ff;
	logic rtc_ff;
	logic lcd_ff;
	logic buz_ff;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			primary_ff <= mft_pkg::PRIMARY_RST;
			secondary_ff <= mft_pkg::SECONDARY_RST;
			rtc_rate_ff <= mft_pkg::RTC_RATE_RST;
			rd_data_ff <= 8'h00;
			armed_ff <= 4'h0;
			irq_ff <= 1'b0;
			vec_ff <= 5'h00;
		end else if (!warm_ff) begin
			primary_ff <= nxt_primary;
			secondary_ff <= nxt_secondary;
			if (wr_rate) rtc_rate_ff <= wr_data[2:0];
			if (rd_en) begin
				rd_data_ff <= (addr == mft_pkg::IRQ_CONTROL_PRIMARY_OFS) ? primary_ff
					: (addr == mft_pkg::IRQ_CONTROL_SECONDARY_OFS) ? secondary_ff
					: (addr == mft_pkg::RTC_RATE_SELECT_OFS) ? {5'h00, rtc_rate_ff} : 8'h00;
			end
			armed_ff <= halt_entry ? ~flags_now : (halted ? armed_ff & ~flags_now : 4'h0);
			irq_ff <= any_pend & ~ack;
			vec_ff <= nxt_vector;
		end
	end
	// Watchdog and reset outcomes
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			warm_ff <= 1'b0;
			chip_ff <= 1'b0;
			wake_ff <= 1'b0;
			to_ff <= 1'b0;
		end else begin
			warm_ff <= wdt_overflow & halted;
			chip_ff <= wdt_overflow & ~halted;
			wake_ff <= halted & ((wdt_overflow) | (|flags_rise));
			if (wdt_overflow) to_ff <= 1'b1;
			else if (halt_entry || (WDT_ENABLE && watchdog_clear_single)) to_ff <= 1'b0;
		end
	end
	// Clock outputs from chain taps
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rtc_ff <= 1'b0;
			lcd_ff <= 1'b0;
			buz_ff <= 1'b0;
		end else begin
			rtc_ff <= rtc_timeout;
			lcd_ff <= chain_count[mft_pkg::LCD_EXP-1];
			buz_ff <= chain_count[int'(BUZ_SEL) + 1];
		end
	end
	assign rd_data = rd_data_ff;
	assign irq_req = irq_ff;
	assign irq_vector = vec_ff;
	assign wake_up = wake_ff;
	assign chip_reset = chip_ff;
	assign warm_reset = warm_ff;
	assign timeout_status = to_ff;
	assign rtc_pulse = rtc_ff;
	assign lcd_clk = lcd_ff;
	assign buzzer_clk = buz_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_warm_in_halt: assert property (@(posedge mclk) disable iff (reset)
		wdt_overflow && halted |=> warm_reset && !chip_reset) else $error("warm reset missing");
	a_chip_in_run: assert property (@(posedge mclk) disable iff (reset)
		wdt_overflow && !halted |=> chip_reset && timeout_status) else $error("chip reset missing");
	a_tb_flag_set: assert property (@(posedge mclk) disable iff (reset)
		tb_timeout && !warm_reset |=> primary_ff[5]) else $error("time base flag not set");
	a_rtc_flag_set: assert property (@(posedge mclk) disable iff (reset)
		rtc_timeout && !warm_reset |=> primary_ff[6]) else $error("rtc flag not set");
	a_sec_zero_bits: assert property (@(posedge mclk) disable iff (reset)
		(secondary_ff & 8'hEE) == 8'h00) else $error("unused bits set");
	a_global_gate: assert property (@(posedge mclk) disable iff (reset)
		!primary_ff[0] && !warm_reset |=> !irq_req) else $error("irq without global enable");
	a_flag_sticky: assert property (@(posedge mclk) disable iff (reset)
		secondary_ff[4] && !wr_secondary && !ack && !warm_reset |=> secondary_ff[4])
		else $error("flag dropped");
	a_tb_vector: assert property (@(posedge mclk) disable iff (reset)
		irq_req && irq_vector == 5'h08 |-> !primary_ff[4] || !primary_ff[1])
		else $error("priority broken");
	a_lcd_rate: assert property (@(posedge mclk) disable iff (reset)
		tick_en && chain_count[2:0] == 3'h3 |=> ##1 $rose(lcd_clk)) else $error("lcd clock");
	c_warm: cover property (@(posedge mclk) disable iff (reset) warm_reset);
	c_chip: cover property (@(posedge mclk) disable iff (reset) chip_reset);
	c_irq_tb: cover property (@(posedge mclk) disable iff (reset) irq_req && irq_vector == 5'h08);
	c_wake: cover property (@(posedge mclk) disable iff (reset) wake_up);
endmodule : mft_timer
`default_nettype wire

// file: mft_pkg.sv
// Package for the multi-function timer, watchdog and interrupt control block.
// Assumes a single clock; the crystal tick arrives as a one-cycle enable.
package mft_pkg;
	localparam logic [7:0] RTC_RATE_SELECT_OFS = 8'h09;
	localparam logic [7:0] IRQ_CONTROL_PRIMARY_OFS = 8'h0B;
	localparam logic [7:0] IRQ_CONTROL_SECONDARY_OFS = 8'h1E;
	// irq_control_primary fields
	localparam int GLOBAL_EN_BIT = 0;
	localparam int EXT_EN_BIT = 1;
	localparam int TB_EN_BIT = 2;
	localparam int RTC_EN_BIT = 3;
	localparam int EXT_FLAG_BIT = 4;
	localparam int TB_FLAG_BIT = 5;
	localparam int RTC_FLAG_BIT = 6;
	// irq_control_secondary fields
	localparam int CNT_EN_BIT = 0;
	localparam int CNT_FLAG_BIT = 4;
	// Reset values
	localparam logic [7:0] PRIMARY_RST = 8'h00;
	localparam logic [7:0] SECONDARY_RST = 8'h00;
	localparam logic [2:0] RTC_RATE_RST = 3'h7;
	// Divider chain layout
	localparam int DIV_STAGES = 7;
	localparam int PRESC_BITS = 8;
	localparam int CHAIN_BITS = DIV_STAGES + PRESC_BITS;
	localparam int RTC_BASE_EXP = 8;
	localparam int LCD_EXP = 3;
	localparam int WDT_EXTRA = 2;
	// Interrupt vectors
	localparam logic [4:0] VEC_EXT = 5'h04;
	localparam logic [4:0] VEC_TB = 5'h08;
	localparam logic [4:0] VEC_RTC = 5'h0C;
	localparam logic [4:0] VEC_CNT = 5'h10;
endpackage : mft_pkg

// file: mft_chain.sv
// Shared 7-stage divider plus 8-bit prescaler and its tap pulses.
// Assumes tick_en is one cycle per crystal period.
`timescale 1ns/100ps
`default_nettype none
module mft_chain #(
	parameter int WIDTH = mft_pkg::CHAIN_BITS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Crystal tick
	input wire logic tick_en,
	// Tap outputs, one bit per stage
	output logic [WIDTH-1:0] count,
	output logic [WIDTH-1:0] tap_pulse
);
	logic [WIDTH-1:0] count_ff;
	logic [WIDTH-1:0] nxt_count;
	assign nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
	// A stage period ends when its bit falls, so every tap comes from one edge
	assign tap_pulse = {WIDTH{tick_en}} & count_ff & ~nxt_count;
	assign count = count_ff;
	// Free running; only the system reset clears it, halt never stops it
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			count_ff <= '0;
		end else if (tick_en) begin
			count_ff <= nxt_count;
		end
	end
endmodule : mft_chain
`default_nettype wire

// file: mft_wdt.sv
// Watchdog: last two stages after the shared chain, with clear schemes.
// Assumes clear strobes are one-cycle instruction pulses.
`timescale 1ns/100ps
`default_nettype none
module mft_wdt (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Options and controls
	input wire logic wdt_enable,
	input wire logic clear_twice,
	input wire logic stage_pulse,
	input wire logic hard_clear,
	input wire logic clr_single,
	input wire logic clr_first,
	input wire logic clr_second,
	// Result
	output logic overflow
);
	logic [1:0] stage_ff;
	logic first_seen_ff;
	logic second_seen_ff;
	logic soft_clear;
	logic [1:0] nxt_stage;
	// One scheme live at a time; the other set of instructions does nothing
	assign soft_clear = clear_twice ? ((first_seen_ff | clr_first) & (second_seen_ff | clr_second))
		: clr_single;
	assign nxt_stage = stage_ff + 2'h1;
	// Overflow at chain carry with both stages full: 3*2^14..2^16 ticks
	assign overflow = wdt_enable & stage_pulse & (stage_ff == 2'h3);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stage_ff <= 2'h0;
			first_seen_ff <= 1'b0;
			second_seen_ff <= 1'b0;
		end else if (!wdt_enable) begin
			// Disabled watchdog ignores every related instruction
			stage_ff <= 2'h0;
			first_seen_ff <= 1'b0;
			second_seen_ff <= 1'b0;
		end else begin
			// Clears reach only these two stages, never the shared chain
			if (hard_clear || soft_clear) begin
				stage_ff <= 2'h0;
			end else if (stage_pulse) begin
				stage_ff <= nxt_stage;
			end
			first_seen_ff <= (clr_first | first_seen_ff) & ~(soft_clear | hard_clear);
			second_seen_ff <= (clr_second | second_seen_ff) & ~(soft_clear | hard_clear);
		end
	end
endmodule : mft_wdt
`default_nettype wire

// file: mft_timer_test.sv
// Self-checking bench for the multi-function timer: register access, interrupts, RTC, halt.
// Assumes tick_en runs every cycle to shorten the chain; mask options set by parameters.
`timescale 1ns/100ps
`default_nettype none
module mft_timer_test;
	////////////////////////////////////////////////////////////////////////////////
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic tick_en = 1'b1;
	logic [7:0] addr = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] rd_data;
	logic halted = 1'b0;
	logic halt_entry = 1'b0;
	logic stack_full = 1'b0;
	logic irq_ack = 1'b0;
	logic ext_irq_event = 1'b0;
	logic counter_overflow = 1'b0;
	logic external_reset_pin_n = 1'b1;
	logic wd_single = 1'b0;
	logic wd_first = 1'b0;
	logic wd_second = 1'b0;
	logic irq_req, wake_up, chip_reset, warm_reset, timeout_status;
	logic rtc_pulse, lcd_clk, buzzer_clk;
	logic [4:0] irq_vector;
	int err_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;
	int seen;

	always #4 mclk = ~mclk;

	// Time base shortened to 2^12 ticks; watchdog on, single clear
	mft_timer #(.TB_SEL(2'h0), .BUZ_SEL(3'h0), .WDT_ENABLE(1'b1), .CLEAR_TWICE(1'b0))
		mft_timer_inst (.mclk(mclk), .reset(reset), .tick_en(tick_en), .addr(addr),
		.wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
		.halted(halted), .halt_entry(halt_entry), .stack_full(stack_full),
		.irq_ack(irq_ack), .ext_irq_event(ext_irq_event),
		.counter_overflow(counter_overflow), .external_reset_pin_n(external_reset_pin_n),
		.watchdog_clear_single(wd_single), .watchdog_clear_first(wd_first),
		.watchdog_clear_second(wd_second), .irq_req(irq_req), .irq_vector(irq_vector),
		.wake_up(wake_up), .chip_reset(chip_reset), .warm_reset(warm_reset),
		.timeout_status(timeout_status), .rtc_pulse(rtc_pulse), .lcd_clk(lcd_clk),
		.buzzer_clk(buzzer_clk));

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("errors %0d, comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	// Two watchdog periods plus the short tests
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 160000) begin
			err_count++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 addr = a;
		wr_data = d;
		wr_en = 1'b1;
		@(posedge mclk);
		#1 wr_en = 1'b0;
	endtask : wr

	// Read data is registered, so it is looked at after the edge that takes rd_en
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
		@(posedge mclk);
		#1 addr = a;
		rd_en = 1'b1;
		@(posedge mclk);
		#1 rd_en = 1'b0;
		chk(rd_data & mask, exp);
	endtask : rd_chk

	function automatic logic sig(input int k);
		case (k)
			0: return irq_req;
			1: return rtc_pulse;
			2: return wake_up;
			3: return chip_reset;
			default: return warm_reset;
		endcase
	endfunction : sig

	// Bounded wait; a missed event is counted as a mismatch
	task automatic wait_for(input int k, input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge mclk);
			#1 cnt++;
			if (k == 4 && wake_up === 1'b1) seen++;
		end while (sig(k) !== 1'b1 && cnt < lim);
		if (cnt >= lim) chk(8'h00, 8'h01);
	endtask : wait_for

	task automatic ack;
		@(posedge mclk);
		#1 irq_ack = 1'b1;
		@(posedge mclk);
		#1 irq_ack = 1'b0;
	endtask : ack

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge mclk);
		#1 reset = 1'b0;
		rd_chk(mft_pkg::IRQ_CONTROL_PRIMARY_OFS, 8'hFF, 8'h00);
		rd_chk(mft_pkg::IRQ_CONTROL_SECONDARY_OFS, 8'hFF, 8'h00);
		rd_chk(mft_pkg::RTC_RATE_SELECT_OFS, 8'h07, 8'h07);
		rd_chk(8'h33, 8'hFF, 8'h00);
		wr(mft_pkg::IRQ_CONTROL_SECONDARY_OFS, 8'hFF);
		rd_chk(mft_pkg::IRQ_CONTROL_SECONDARY_OFS, 8'hFF, 8'h11);
		wr(mft_pkg::IRQ_CONTROL_SECONDARY_OFS, 8'h01);
		// Coinciding requests: external wins, counter request waits
		wr(mft_pkg::IRQ_CONTROL_PRIMARY_OFS, 8'h0F);
		@(posedge mclk);
		#1 ext_irq_event = 1'b1;
		counter_overflow = 1'b1;
		@(posedge mclk);
		#1 ext_irq_event = 1'b0;
		counter_overflow = 1'b0;
		wait_for(0, 5, n);
		chk({3'h0, irq_vector}, 8'h04);
		ack();
		#1 chk({7'h0, irq_req}, 8'h00);
		rd_chk(mft_pkg::IRQ_CONTROL_PRIMARY_OFS, 8'hFF, 8'h0E);
		rd_chk(mft_pkg::IRQ_CONTROL_SECONDARY_OFS, 8'hFF, 8'h11);
		wr(mft_pkg::IRQ_CONTROL_PRIMARY_OFS, 8'h0F);
		wait_for(0, 5, n);
		chk({3'h0, irq_vector}, 8'h10);
		ack();
		rd_chk(mft_pkg::IRQ_CONTROL_SECONDARY_OFS, 8'hFF, 8'h01);
		// Full stack holds back a pending time base request
		stack_full = 1'b1;
		wr(mft_pkg::IRQ_CONTROL_PRIMARY_OFS, 8'h25);
		repeat (3) @(posedge mclk);
		#1 chk({7'h0, irq_req}, 8'h00);
		stack_full = 1'b0;
		wait_for(0, 5, n);
		chk({3'h0, irq_vector}, 8'h08);
		ack();
		wr(mft_pkg::IRQ_CONTROL_PRIMARY_OFS, 8'h00);
		// LCD clock repeats every 8 ticks, buzzer every 4; start on an LCD rise to fix the phase
		@(posedge lcd_clk);
		#1 n = {lcd_clk, buzzer_clk};
		repeat (2) @(posedge mclk);
		#1 chk({6'h0, lcd_clk, buzzer_clk}, {6'h0, n[1], ~n[0]});
		repeat (2) @(posedge mclk);
		#1 chk({6'h0, lcd_clk, buzzer_clk}, {6'h0, ~n[1], n[0]});
		repeat (4) @(posedge mclk);
		#1 chk({6'h0, lcd_clk}, {7'h0, n[1]});
		// RTC period for codes 0 to 3; second interval avoids the rate change
		for (int c = 0; c < 4; c++) begin
			wr(mft_pkg::RTC_RATE_SELECT_OFS, c[7:0]);
			wait_for(1, 5000, n);
			wait_for(1, 5000, n);
			chk(8'(n >> 8), 8'(1 << c));
		end
		rd_chk(mft_pkg::IRQ_CONTROL_PRIMARY_OFS, 8'h40, 8'h40);
		// Halt with time base flag clear: the time base wakes the core
		wr(mft_pkg::IRQ_CONTROL_PRIMARY_OFS, 8'h40);
		@(posedge mclk);
		#1 halt_entry = 1'b1;
		halted = 1'b1;
		@(posedge mclk);
		#1 halt_entry = 1'b0;
		wait_for(2, 4200, n);
		halted = 1'b0;
		rd_chk(mft_pkg::IRQ_CONTROL_PRIMARY_OFS, 8'hFF, 8'h60);
		// Normal overflow, counted from the clear at halt entry
		// Halt entry lies 0 to 4300 cycles before the start of this count
		wait_for(3, 70000, n);
		chk({7'h0, n + 4300 >= 32768 && n <= 65540}, 8'h01);
		@(posedge mclk);
		#1 chk({7'h0, timeout_status}, 8'h01);
		// Halt with flags already set: only the watchdog may wake
		@(posedge mclk);
		#1 halt_entry = 1'b1;
		halted = 1'b1;
		@(posedge mclk);
		#1 halt_entry = 1'b0;
		seen = 0;
		wait_for(4, 70000, n);
		chk({7'h0, n >= 32766 && n <= 65540}, 8'h01);
		// The only wake pulse seen is the one that comes with the warm reset
		chk({6'h0, chip_reset, seen != 1}, 8'h00);
		chk({7'h0, wake_up}, 8'h01);
		halted = 1'b0;
		rd_chk(mft_pkg::IRQ_CONTROL_PRIMARY_OFS, 8'hFF, 8'h60);
		report_and_stop();
	end
endmodule : mft_timer_test
`default_nettype wire
